/* File: src/fws_pkg.sv */
// package for the flash write-status host controller
// assumes a byte-wide asynchronous flash on a parallel bus driven by this host
//
// Summary of operation
// - host reads the data byte twice and compares toggle bits before deciding.
// - if still toggling, host checks timing-limit flag and re-tests toggle bit.
// - still toggling after flag high means failure; host writes reset command.
// - polling that was abandoned restarts from the first toggle read.
// - after any timing-limit failure host writes the reset command.
// - host may skip timer flag only if extra commands come within 50 us.
// - after sector erase, host confirms by poll or toggle, then reads timer.
// - host reads timer flag before and after each extra sector command.
// - poll-bit reads use the program address or a selected-sector address.
// - reset command is needed to leave status once timing-limit flag is high.

package fws_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned ADDR_W          = 17;
  // bit positions within the status byte
  localparam int unsigned BIT_POLL        = 7;
  localparam int unsigned BIT_TOGGLE      = 6;
  localparam int unsigned BIT_TLIMIT      = 5;
  localparam int unsigned BIT_SETIMER     = 3;
  // bus strobe timing in cycles (25 ns each); the pulse must outlast the
  // four-edge input synchroniser, or the byte taken is the one before the strobe
  localparam int unsigned BUS_SETUP_CYC   = 1;
  localparam int unsigned BUS_PULSE_CYC   = 5;
  localparam int unsigned BUS_RECOV_CYC   = 2;
  // selection window of the sector erase sequence
  localparam int unsigned SE_WINDOW_US    = 50;
  localparam int unsigned SE_WINDOW_CYC   = (SE_WINDOW_US * (CLK_HZ / 1_000_000));
  // command code of the reset write
  localparam logic [7:0]  CMD_RESET       = 8'hF0;
  // register offsets of the software port
  localparam logic [3:0]  OFS_CTRL        = 4'h0;
  localparam logic [3:0]  OFS_ADDR        = 4'h1;
  localparam logic [3:0]  OFS_STATUS      = 4'h2;
  localparam logic [3:0]  OFS_LASTBYTE    = 4'h3;
  localparam logic [3:0]  OFS_TIMER       = 4'h4;
  // control bits
  localparam int unsigned CTRL_START      = 0;
  localparam int unsigned CTRL_TIMER      = 1;
  localparam int unsigned CTRL_ABORT      = 2;

  // one flash bus cycle request
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fws_req_s;

  // flash pins driven by the host
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        dq_o;
    logic              dq_oe;
  } fws_pins_s;

  // outcome of a status poll
  typedef enum logic [1:0] {
    FWS_RES_BUSY,
    FWS_RES_DONE,
    FWS_RES_FAIL
  } fws_res_e;

  // toggle bit of two bytes differs
  function automatic logic fws_toggled(input logic [7:0] a, input logic [7:0] b);
    fws_toggled = a[BIT_TOGGLE] ^ b[BIT_TOGGLE];
  endfunction : fws_toggled

endpackage : fws_pkg

/* File: src/fws_bus_cycle.sv */
// one asynchronous flash read or write cycle on the parallel pins
// assumes the data bus input is already synchronised by the caller
`timescale 1ns/100ps

module fws_bus_cycle
  import fws_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      req_valid,
  output logic           req_ready,
  input  wire fws_req_s  req,
  input  wire logic [7:0] dq_i,
  output fws_pins_s      pins,
  output logic           rsp_valid,
  output logic [7:0]     rsp_data
);

  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_PULSE, BC_RECOV} fws_bc_e;

  fws_bc_e    st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  fws_req_s   req_q, req_d;
  logic       rsp_valid_q, rsp_valid_d;
  logic [7:0] rsp_data_q, rsp_data_d;

  assign req_ready = (st_q == BC_IDLE);

  // next-state: setup, strobe pulse, then recovery with strobes high
  always_comb
  begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    req_d       = req_q;
    rsp_valid_d = 1'b0;
    rsp_data_d  = rsp_data_q;
    unique case (st_q)
      BC_IDLE:
      begin
        if (req_valid)
        begin
          req_d = req;
          cnt_d = 4'(BUS_SETUP_CYC);
          st_d  = BC_SETUP;
        end
      end
      BC_SETUP:
      begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1)
        begin
          cnt_d = 4'(BUS_PULSE_CYC);
          st_d  = BC_PULSE;
        end
      end
      BC_PULSE:
      begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1)
        begin
          // sample late in the pulse; input path adds sync delay already
          rsp_data_d  = dq_i;
          rsp_valid_d = ~req_q.wr;
          cnt_d       = 4'(BUS_RECOV_CYC);
          st_d        = BC_RECOV;
        end
      end
      BC_RECOV:
      begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1)
          st_d = BC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q        <= BC_IDLE;
      cnt_q       <= 4'h0;
      req_q       <= '0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end
    else
    begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      req_q       <= req_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q  <= rsp_data_d;
    end
  end

  // pins: chip select across setup and pulse, strobe only in pulse
  always_comb
  begin
    pins.ce_n  = ~((st_q == BC_SETUP) || (st_q == BC_PULSE));
    pins.oe_n  = ~((st_q == BC_PULSE) && !req_q.wr);
    pins.we_n  = ~((st_q == BC_PULSE) && req_q.wr);
    pins.addr  = req_q.addr;
    pins.dq_o  = req_q.data;
    pins.dq_oe = req_q.wr && (st_q != BC_IDLE);
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data  = rsp_data_q;

endmodule : fws_bus_cycle

/* File: src/fws_status_host.sv */
// host-side status poller for a byte-wide flash running an internal algorithm
// assumes software starts a poll after it has written a program or erase sequence
`timescale 1ns/100ps

module fws_status_host
  import fws_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // software port
  input  wire logic [3:0]        sw_addr,
  input  wire logic [31:0]       sw_wdata,
  input  wire logic              sw_wr,
  input  wire logic              sw_rd,
  output logic [31:0]            sw_rdata,
  // flash pins
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n,
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [7:0]             fl_dq_o,
  output logic                   fl_dq_oe,
  input  wire logic [7:0]        fl_dq_i
);

  // ****************************************************************
  // input synchroniser
  // ****************************************************************
  logic [7:0] dq_s1_q, dq_s2_q, dq_s3_q, dq_q;

  // three stages; the byte is taken once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      dq_s3_q <= 8'h00;
      dq_q    <= 8'h00;
    end
    else
    begin
      dq_s1_q <= fl_dq_i;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
      if (dq_s2_q == dq_s3_q)
        dq_q <= dq_s3_q;
    end
  end

  // ****************************************************************
  // bus cycle engine
  // ****************************************************************
  logic       cyc_valid, cyc_ready, rsp_valid, rsp_raw;
  fws_req_s   cyc_req;
  logic [7:0] rsp_data;
  fws_pins_s  pins;

  fws_bus_cycle u_cyc
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .req_valid (cyc_valid),
    .req_ready (cyc_ready),
    .req       (cyc_req),
    .dq_i      (dq_q),
    .pins      (pins),
    .rsp_valid (rsp_raw),
    .rsp_data  (rsp_data)
  );

  assign fl_ce_n  = pins.ce_n;
  assign fl_oe_n  = pins.oe_n;
  assign fl_we_n  = pins.we_n;
  assign fl_addr  = pins.addr;
  assign fl_dq_o  = pins.dq_o;
  assign fl_dq_oe = pins.dq_oe;

  // ****************************************************************
  // polling sequencer
  // ****************************************************************
  typedef enum logic [2:0] {
    PS_IDLE, PS_RD1, PS_RD2, PS_RECHK1, PS_RECHK2, PS_RESET, PS_TIMER
  } fws_ps_e;

  fws_ps_e           ps_q, ps_d;
  logic              issued_q, issued_d;
  logic [7:0]        first_q, first_d;
  logic [7:0]        last_q, last_d;
  fws_res_e          res_q, res_d;
  logic              timer_q, timer_d;
  logic [ADDR_W-1:0] vaddr_q, vaddr_d;

  wire start_cmd = sw_wr && (sw_addr == OFS_CTRL) && sw_wdata[CTRL_START];
  wire timer_cmd = sw_wr && (sw_addr == OFS_CTRL) && sw_wdata[CTRL_TIMER];
  wire abort_cmd = sw_wr && (sw_addr == OFS_CTRL) && sw_wdata[CTRL_ABORT];

  // an answer counts only for a read this poll issued; one still in flight
  // from an aborted poll would otherwise pose as the first read of the next
  assign rsp_valid = rsp_raw && issued_q;

  // each state but idle and reset issues one flash read and waits for its answer
  always_comb
  begin
    ps_d      = ps_q;
    issued_d  = issued_q;
    first_d   = first_q;
    last_d    = last_q;
    res_d     = res_q;
    timer_d   = timer_q;
    vaddr_d   = vaddr_q;
    cyc_valid = 1'b0;
    cyc_req   = '{wr: 1'b0, addr: vaddr_q, data: CMD_RESET};
    if (sw_wr && (sw_addr == OFS_ADDR))
      vaddr_d = sw_wdata[ADDR_W-1:0];
    if (ps_q != PS_IDLE && ps_q != PS_RESET && !issued_q)
    begin
      cyc_valid = 1'b1;
      issued_d  = cyc_ready;
    end
    unique case (ps_q)
      PS_IDLE:
      begin
        if (start_cmd)
        begin
          ps_d     = PS_RD1;
          issued_d = 1'b0;
          res_d    = FWS_RES_BUSY;
        end
        else if (timer_cmd)
        begin
          ps_d     = PS_TIMER;
          issued_d = 1'b0;
        end
      end
      PS_RD1:
      begin
        if (rsp_valid)
        begin
          first_d  = rsp_data;
          last_d   = rsp_data;
          issued_d = 1'b0;
          ps_d     = PS_RD2;
        end
      end
      PS_RD2, PS_RECHK2:
      begin
        if (rsp_valid)
        begin
          last_d   = rsp_data;
          issued_d = 1'b0;
          if (!fws_toggled(first_q, rsp_data))
          begin
            res_d = FWS_RES_DONE;
            ps_d  = PS_IDLE;
          end
          else if (ps_q == PS_RECHK2)
            ps_d = PS_RESET;
          else if (rsp_data[BIT_TLIMIT])
            ps_d = PS_RECHK1;
          else
          begin
            first_d = rsp_data;
            ps_d    = PS_RD2;
          end
        end
      end
      PS_RECHK1:
      begin
        if (rsp_valid)
        begin
          first_d  = rsp_data;
          last_d   = rsp_data;
          issued_d = 1'b0;
          ps_d     = PS_RECHK2;
        end
      end
      PS_RESET:
      begin
        cyc_valid = 1'b1;
        cyc_req   = '{wr: 1'b1, addr: vaddr_q, data: CMD_RESET};
        if (cyc_ready)
        begin
          res_d = FWS_RES_FAIL;
          ps_d  = PS_IDLE;
        end
      end
      PS_TIMER:
      begin
        if (rsp_valid)
        begin
          last_d   = rsp_data;
          timer_d  = rsp_data[BIT_SETIMER];
          issued_d = 1'b0;
          ps_d     = PS_IDLE;
        end
      end
    endcase
    // abandoning a poll; the next start begins at the first read again
    if (abort_cmd && ps_q != PS_RESET)
    begin
      ps_d     = PS_IDLE;
      issued_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ps_q     <= PS_IDLE;
      issued_q <= 1'b0;
      first_q  <= 8'h00;
      last_q   <= 8'h00;
      res_q    <= FWS_RES_BUSY;
      timer_q  <= 1'b0;
      vaddr_q  <= '0;
    end
    else
    begin
      ps_q     <= ps_d;
      issued_q <= issued_d;
      first_q  <= first_d;
      last_q   <= last_d;
      res_q    <= res_d;
      timer_q  <= timer_d;
      vaddr_q  <= vaddr_d;
    end
  end

  // ****************************************************************
  // software read port
  // ****************************************************************
  logic [31:0] rdata_q, rdata_d;

  // read data appear the cycle after the strobe and only then
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (sw_rd)
    begin
      unique case (sw_addr)
        OFS_ADDR:     rdata_d = 32'(vaddr_q);
        OFS_STATUS:   rdata_d = {28'h0, (ps_q != PS_IDLE), 1'b0, res_q};
        OFS_LASTBYTE: rdata_d = {24'h0, last_q};
        OFS_TIMER:    rdata_d = {31'h0, timer_q};
        default:      rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  assign sw_rdata = rdata_q;

endmodule : fws_status_host

/* File: sim/fws_status_host_properties.sv */
// checker: port-level properties of the flash status host
// assumes it is bound onto fws_status_host and sees only its ports
`timescale 1ns/100ps

module fws_status_host_properties
  import fws_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [3:0]        sw_addr,
  input  wire logic [31:0]       sw_wdata,
  input  wire logic              sw_wr,
  input  wire logic              sw_rd,
  input  wire logic [31:0]       sw_rdata,
  input  wire logic              fl_ce_n,
  input  wire logic              fl_oe_n,
  input  wire logic              fl_we_n,
  input  wire logic [ADDR_W-1:0] fl_addr,
  input  wire logic [7:0]        fl_dq_o,
  input  wire logic              fl_dq_oe,
  input  wire logic [7:0]        fl_dq_i
);
  // ********************
  // read counter
  // ********************
  logic [2:0] rd_cnt_q, rd_cnt_d;
  logic       oe_n_q,   oe_n_d;

  // reads since the last write or control command; saturates so a long poll cannot wrap
  always_comb
  begin
    oe_n_d   = sys_rst | fl_oe_n;
    rd_cnt_d = rd_cnt_q;
    if (sys_rst || !fl_we_n || (sw_wr && sw_addr == OFS_CTRL))
      rd_cnt_d = 3'h0;
    else if (oe_n_q && !fl_oe_n && rd_cnt_q != 3'h7)
      rd_cnt_d = rd_cnt_q + 3'h1;
  end

  // registers only
  always_ff @(posedge clk)
  begin
    rd_cnt_q <= rd_cnt_d;
    oe_n_q   <= oe_n_d;
  end

  // ********************
  // properties
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_read_pulse: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*5] ##1 fl_oe_n)
    else $error("read strobe width wrong");
  chk_read_recov: assert property ($rose(fl_oe_n) |-> fl_ce_n [*2])
    else $error("no recovery after read");
  chk_addr_steady: assert property (!fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr))
    else $error("address moved inside a bus cycle");
  chk_bus_free: assert property (!fl_oe_n |-> !fl_dq_oe && !fl_ce_n && fl_we_n)
    else $error("host drives data during a read");
  chk_reset_cmd: assert property (!fl_we_n |-> !fl_ce_n && fl_dq_oe && fl_dq_o == CMD_RESET)
    else $error("write is not the reset command");
  chk_write_pulse: assert property ($fell(fl_we_n) |-> !fl_we_n [*5] ##1 fl_we_n)
    else $error("write strobe width wrong");
  chk_fail_reads: assert property ($fell(fl_we_n) |-> rd_cnt_q >= 3'h4)
    else $error("failure declared with fewer than four reads");
  chk_rdata_idle: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
    else $error("read data outside its cycle");

  cov_reset_write: cover property ($fell(fl_we_n));
  cov_flash_read: cover property ($rose(fl_oe_n));
  cov_status_read: cover property (sw_rd && sw_addr == OFS_STATUS);
  cov_timer_cmd: cover property (sw_wr && sw_addr == OFS_CTRL && sw_wdata[CTRL_TIMER]);
endmodule : fws_status_host_properties

/* File: sim/fws_flash_model.sv */
// behavioural flash: status byte while an algorithm runs, array byte otherwise
// assumes the host keeps ce_n low across each strobe
`timescale 1ns/100ps

module fws_flash_model
  import fws_pkg::*;
#(
  parameter logic [7:0] ARRAY_BYTE = 8'h5A
)
(
  input  wire logic       fl_ce_n,
  input  wire logic       fl_oe_n,
  input  wire logic       fl_we_n,
  input  wire logic [7:0] fl_dq_o,
  input  wire logic       fl_dq_oe,
  output logic [7:0]      fl_dq_i
);
  // ********************
  // device state
  // ********************
  int         reads_left = 0;
  int         resets     = 0;
  logic       limit_hit  = 1'b0;
  logic       tog        = 1'b0;
  logic [7:0] out_q      = 8'h00;
  logic       window_open = 1'b0;

  // test hook: an algorithm lasting n status reads, lim stuck for ever
  // lim stands for a one written over a zero: halted, flag up
  task automatic arm(input int n, input logic lim);
    reads_left = n;
    limit_hit  = lim;
  endtask : arm

  always @(negedge fl_oe_n)
  begin
    if (!fl_ce_n && reads_left > 0)
    begin
      tog        = ~tog;
      reads_left = reads_left - 1;
      // timer flag high once the window has closed
      out_q      = {~ARRAY_BYTE[7], tog, limit_hit, 1'b0, ~window_open, 3'h0};
    end
    else if (!fl_ce_n)
      out_q = ARRAY_BYTE;
  end

  always @(negedge fl_we_n)
  begin
    if (!fl_ce_n && fl_dq_oe && fl_dq_o == CMD_RESET)
    begin
      reads_left = 0;
      resets     = resets + 1;
    end
  end

  // no pull on the bus, so a released bus shows the inverse of the last byte
  assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? out_q : ~out_q;
endmodule : fws_flash_model

/* File: sim/test_fws_status_host.sv */
// testbench: status host polling a behavioural flash
// assumes fws_flash_model on the pins and the checker bound below
`timescale 1ns/100ps

module test_fws_status_host
  import fws_pkg::*;
;
  // ********************
  // harness
  // ********************
  typedef struct {int n; logic lim; fws_res_e res;} fws_row_s;
  localparam logic [7:0] ARR = 8'h5A;
  logic              clk      = 1'b0;
  logic              sys_rst  = 1'b1;
  logic [3:0]        sw_addr  = 4'h0;
  logic [31:0]       sw_wdata = 32'h0;
  logic              sw_wr    = 1'b0;
  logic              sw_rd    = 1'b0;
  logic [31:0]       sw_rdata, d;
  logic              fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
  logic [ADDR_W-1:0] fl_addr;
  logic [7:0]        fl_dq_o, fl_dq_i;
  int                err_total = 0;
  int                checked   = 0;
  int                r0;
  // ready at once, slow, limit with late stop, stuck until reset
  fws_row_s rows [4] = '{'{0, 1'b0, FWS_RES_DONE}, '{5, 1'b0, FWS_RES_DONE},
                         '{2, 1'b1, FWS_RES_DONE}, '{1000, 1'b1, FWS_RES_FAIL}};

  // 40 MHz
  always #12.5 clk = ~clk;

  fws_status_host i_fws_status_host (.clk, .sys_rst, .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
    .sw_rdata, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_dq_i);
  fws_flash_model #(.ARRAY_BYTE(ARR)) i_fws_flash_model (.fl_ce_n, .fl_oe_n, .fl_we_n,
    .fl_dq_o, .fl_dq_oe, .fl_dq_i);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= v;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr    <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd   <= 1'b0;
    #1 v = sw_rdata;
  endtask : rd

  // issue a control command and read status until busy clears, bounded
  task automatic poll(input logic [31:0] cmd);
    wr(OFS_CTRL, cmd);
    d = 32'h8;
    for (int i = 0; i < 400 && d[3] !== 1'b0; i++)
      rd(OFS_STATUS, d);
  endtask : poll

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check("strobes idle", {29'h0, fl_ce_n, fl_oe_n, fl_we_n}, 32'h7);
    check("bus released", {31'h0, fl_dq_oe}, 32'h0);
    $display("reset test finished");
    foreach (rows[k])
    begin
      i_fws_flash_model.arm(rows[k].n, rows[k].lim);
      r0 = i_fws_flash_model.resets;
      poll(32'h1);
      check("result", {30'h0, d[1:0]}, {30'h0, rows[k].res});
      check("reset writes", 32'(i_fws_flash_model.resets - r0), {31'h0, rows[k].lim && rows[k].n > 4});
      rd(OFS_LASTBYTE, d);
      if (rows[k].res == FWS_RES_DONE)
        check("array byte", d, {24'h0, ARR});
      $display("row %0d finished", k);
    end
    // abandon a long poll, then start over on a finished device
    i_fws_flash_model.arm(1000, 1'b0);
    wr(OFS_CTRL, 32'h1);
    repeat (60) @(posedge clk);
    wr(OFS_CTRL, 32'h4);
    i_fws_flash_model.arm(0, 1'b0);
    poll(32'h1);
    check("restart result", {30'h0, d[1:0]}, {30'h0, FWS_RES_DONE});
    rd(4'hF, d);
    check("unmapped read", d, 32'h0);
    // timer flag while the selection window is open, then after it closes
    wr(OFS_ADDR, 32'h0001_2345);
    i_fws_flash_model.window_open = 1'b1;
    i_fws_flash_model.arm(3, 1'b0);
    poll(32'h2);
    rd(OFS_TIMER, d);
    check("timer open", d, 32'h0);
    i_fws_flash_model.window_open = 1'b0;
    poll(32'h2);
    rd(OFS_TIMER, d);
    check("timer closed", d, 32'h1);
    check("flash address", 32'(fl_addr), 32'h0001_2345);
    rd(OFS_ADDR, d);
    check("address readback", d, 32'h0001_2345);
    $display("awkward tests finished");
    wrap_up();
  end

  // whole run needs well under 20000 cycles; this cuts a hang short
  initial
  begin
    #2000000;
    err_total++;
    wrap_up();
  end
endmodule : test_fws_status_host

bind fws_status_host fws_status_host_properties i_fws_status_host_properties (.clk, .sys_rst,
  .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_addr,
  .fl_dq_o, .fl_dq_oe, .fl_dq_i);
